// ---- hdl/sgl_pkg.sv ----
// package of constants and types for the scatter gather descriptor decoder
package sgl_pkg;
  localparam int DESC_BITS = 128;
  localparam int ID_LSB = 120;
  localparam int SUB_LSB = 120;
  localparam int TYPE_LSB = 124;
  localparam int ADDR_LSB = 0;
  localparam int LEN_LSB = 64;
  localparam int KLEN_BITS = 24;

  localparam logic [3:0] TYPE_DATA = 4'h0;
  localparam logic [3:0] TYPE_BUCKET = 4'h1;
  localparam logic [3:0] TYPE_SEG = 4'h2;
  localparam logic [3:0] TYPE_LAST_SEG = 4'h3;
  localparam logic [3:0] TYPE_KEYED = 4'h4;
  localparam logic [3:0] TYPE_VENDOR = 4'hF;
  localparam logic [3:0] SUB_ADDR = 4'h0;
  localparam logic [3:0] SUB_OFFSET = 4'h1;
  localparam logic [3:0] SUB_XPORT_LO = 4'hA;

  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_TYPE = 3'h1;
  localparam logic [2:0] ERR_FIELD = 3'h2;
  localparam logic [2:0] ERR_LENGTH = 3'h3;

  // register map, one aligned word each
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h8;
  localparam logic [3:0] REG_IRQ_CLR = 4'hC;
  localparam logic [4:0] REG_IRQ_EN = 5'h10;
  localparam logic [4:0] REG_COUNT = 5'h14;

  localparam int CTRL_DWORD_BIT = 0;
  localparam int CTRL_PCIE_BIT = 1;
  localparam int CTRL_CHECK_BIT = 2;
  localparam int CTRL_VENDOR_BIT = 3;
  localparam int CTRL_XPORT_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h07;

  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_BITS = 2;
endpackage

// ---- hdl/sgl_avalon_slave.sv ----
// avalon-mm register slave: one wait state on every access
`timescale 1ns/1ps
module sgl_avalon_slave (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [4:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  output logic             waitrequest_out,
  output logic             wr_strobe_out,
  output logic             rd_strobe_out,
  output logic [4:0]       reg_addr_out,
  output logic [31:0]      reg_wdata_out
);
  logic served;

  // a request is taken on the edge where waitrequest is low
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      served <= 1'b0;
    end else begin
      served <= (read_in || write_in) && !served;
    end
  end

  always_comb begin
    waitrequest_out = (read_in || write_in) && !served;
    wr_strobe_out   = write_in && served;
    rd_strobe_out   = read_in && served;
    reg_addr_out    = address_in;
    reg_wdata_out   = writedata_in;
  end
endmodule

// ---- hdl/sgl_descriptor_decoder.sv ----
// scatter gather descriptor decoder with avalon-mm control registers
`timescale 1ns/1ps
// Summary of operation
// - byte 15 is the identifier; low nibble sub type, high nibble type.
// - reserved or unsupported type codes raise the descriptor-type error.
// - types: 0 data, 1 bucket, 2 segment, 3 last segment, 4 keyed, F vendor.
// - reserved or unsupported sub types raise the same descriptor-type error.
// - an all-zero descriptor is accepted as a null data block.
// - sub type 0 on types 0,2,3,4 means absolute 64-bit byte address.
// - sub type 1 on types 0,2,3 is an offset; reserved on pcie transport.
// - sub types A to F follow the transport binding in use.
// - data block address comes from bytes 7:0, absolute or offset.
// - nonzero low address bits may error, else are treated as zero.
// - length is a byte count; zero length is still valid.
// - address plus length beyond 64-bit space flags a length error.
module sgl_descriptor_decoder (
  input  wire logic          clock_in,
  input  wire logic          rst_in,
  input  wire logic          desc_valid_in,
  input  wire logic [127:0]  desc_in,
  input  wire logic          xport_sub_ok_in,
  output logic               out_valid_out,
  output logic [3:0]         out_type_out,
  output logic [3:0]         out_sub_out,
  output logic [63:0]        out_addr_out,
  output logic [31:0]        out_len_out,
  output logic               out_is_offset_out,
  output logic               out_null_out,
  output logic [2:0]         out_err_out,
  input  wire logic [4:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  output logic               irq_out
);
  logic [4:0]  ctrl;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_en;
  logic [15:0] count;
  logic [2:0]  last_err;
  logic        wr_strobe;
  logic        rd_strobe;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        bus_wait;

  logic [3:0]  id_type;
  logic [3:0]  id_sub;
  logic [63:0] raw_addr;
  logic [31:0] raw_len;
  logic        type_bad;
  logic        sub_bad;
  logic        low_bits_bad;
  logic        overflow;
  logic [64:0] addr_sum;
  logic [2:0]  next_err;
  logic        is_data;

  sgl_avalon_slave u_slave (
    .clock_in        (clock_in),
    .rst_in          (rst_in),
    .address_in      (avs_address),
    .read_in         (avs_read),
    .write_in        (avs_write),
    .writedata_in    (avs_writedata),
    .waitrequest_out (bus_wait),
    .wr_strobe_out   (wr_strobe),
    .rd_strobe_out   (rd_strobe),
    .reg_addr_out    (reg_addr),
    .reg_wdata_out   (reg_wdata)
  );

  // waitrequest is combinational off the slave state so a read completes
  // on the second edge; registering it would add a cycle to every access
  always_comb begin
    avs_waitrequest = bus_wait;
  end

  // true when the type code is one this decoder handles
  function automatic logic type_supported(input logic [3:0] t,
                                          input logic vendor_ok);
    unique case (t)
      sgl_pkg::TYPE_DATA,
      sgl_pkg::TYPE_BUCKET,
      sgl_pkg::TYPE_SEG,
      sgl_pkg::TYPE_LAST_SEG,
      sgl_pkg::TYPE_KEYED:   type_supported = 1'b1;
      sgl_pkg::TYPE_VENDOR:  type_supported = vendor_ok;
      default:               type_supported = 1'b0;
    endcase
  endfunction

  // true when the sub type is legal for the given type
  function automatic logic sub_supported(input logic [3:0] t,
                                         input logic [3:0] s,
                                         input logic pcie,
                                         input logic xport_ok);
    if (s == sgl_pkg::SUB_ADDR) begin
      sub_supported = (t != sgl_pkg::TYPE_BUCKET) &&
                      (t != sgl_pkg::TYPE_VENDOR);
    end else if (s == sgl_pkg::SUB_OFFSET) begin
      sub_supported = !pcie && (t == sgl_pkg::TYPE_DATA ||
                      t == sgl_pkg::TYPE_SEG ||
                      t == sgl_pkg::TYPE_LAST_SEG);
    end else if (s >= sgl_pkg::SUB_XPORT_LO) begin
      sub_supported = xport_ok;
    end else begin
      sub_supported = 1'b0;
    end
  endfunction

  always_comb begin
    id_type  = desc_in[sgl_pkg::TYPE_LSB +: 4];
    id_sub   = desc_in[sgl_pkg::SUB_LSB +: 4];
    raw_addr = desc_in[sgl_pkg::ADDR_LSB +: 64];
    raw_len  = desc_in[sgl_pkg::LEN_LSB +: 32];
    is_data  = (id_type == sgl_pkg::TYPE_DATA) ||
               (id_type == sgl_pkg::TYPE_KEYED);
    // the bucket type has no sub type 0 use, but its null sub type is benign
    type_bad = !type_supported(id_type, ctrl[sgl_pkg::CTRL_VENDOR_BIT]);
    sub_bad  = !sub_supported(id_type, id_sub,
                              ctrl[sgl_pkg::CTRL_PCIE_BIT],
                              ctrl[sgl_pkg::CTRL_XPORT_BIT] &&
                              xport_sub_ok_in);
    if (id_type == sgl_pkg::TYPE_BUCKET && id_sub == sgl_pkg::SUB_ADDR) begin
      sub_bad = 1'b0;
    end
    low_bits_bad = is_data && ctrl[sgl_pkg::CTRL_DWORD_BIT] &&
                   ((raw_addr[1:0] != 2'b00) || (raw_len[1:0] != 2'b00));
    addr_sum = {1'b0, raw_addr} + {33'h0, raw_len};
    // only absolute addresses can run off the end of the space
    overflow = is_data && (id_sub == sgl_pkg::SUB_ADDR) &&
               addr_sum[64] && (addr_sum[63:0] != 64'h0);
    if (type_bad || sub_bad) begin
      next_err = sgl_pkg::ERR_TYPE;
    end else if (low_bits_bad && ctrl[sgl_pkg::CTRL_CHECK_BIT]) begin
      next_err = sgl_pkg::ERR_FIELD;
    end else if (overflow) begin
      next_err = sgl_pkg::ERR_LENGTH;
    end else begin
      next_err = sgl_pkg::ERR_NONE;
    end
  end

  // decoded result, held until the next descriptor
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      out_valid_out     <= 1'b0;
      out_type_out      <= 4'h0;
      out_sub_out       <= 4'h0;
      out_addr_out      <= 64'h0;
      out_len_out       <= 32'h0;
      out_is_offset_out <= 1'b0;
      out_null_out      <= 1'b0;
      out_err_out       <= 3'h0;
    end else begin
      out_valid_out <= desc_valid_in;
      if (desc_valid_in) begin
        out_type_out <= id_type;
        out_sub_out  <= id_sub;
        // in dword mode, low bits are dropped as if zero, with checking on or off
        if (is_data && ctrl[sgl_pkg::CTRL_DWORD_BIT]) begin
          out_addr_out <= {raw_addr[63:2], 2'b00};
          out_len_out  <= {raw_len[31:2], 2'b00};
        end else begin
          out_addr_out <= raw_addr;
          out_len_out  <= (id_type == sgl_pkg::TYPE_KEYED) ?
                          {8'h00, raw_len[sgl_pkg::KLEN_BITS-1:0]} :
                          raw_len;
        end
        out_is_offset_out <= (id_sub == sgl_pkg::SUB_OFFSET) && !sub_bad;
        out_null_out <= (desc_in == 128'h0);
        out_err_out  <= next_err;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctrl   <= sgl_pkg::CTRL_RESET;
      irq_en <= 2'b00;
    end else if (wr_strobe) begin
      if (reg_addr == {1'b0, sgl_pkg::REG_CTRL}) begin
        ctrl <= reg_wdata[4:0];
      end
      if (reg_addr == sgl_pkg::REG_IRQ_EN) begin
        irq_en <= reg_wdata[1:0];
      end
    end
  end

  // sticky events; a set in the clearing cycle wins
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_stat <= 2'b00;
    end else begin
      irq_stat <= (irq_stat &
                   ~((wr_strobe &&
                      reg_addr == {1'b0, sgl_pkg::REG_IRQ_CLR}) ?
                     reg_wdata[1:0] : 2'b00)) |
                  {desc_valid_in && next_err != sgl_pkg::ERR_NONE,
                   desc_valid_in};
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      count    <= 16'h0;
      last_err <= 3'h0;
      irq_out  <= 1'b0;
    end else begin
      irq_out <= |(irq_stat & irq_en);
      if (desc_valid_in) begin
        count    <= count + 16'h1;
        last_err <= next_err;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      avs_readdata <= 32'h0;
    end else if (bus_wait && avs_read) begin
      unique case (reg_addr)
        {1'b0, sgl_pkg::REG_CTRL}:     avs_readdata <= {27'h0, ctrl};
        {1'b0, sgl_pkg::REG_STATUS}:   avs_readdata <= {29'h0, last_err};
        {1'b0, sgl_pkg::REG_IRQ_STAT}: avs_readdata <= {30'h0, irq_stat};
        sgl_pkg::REG_IRQ_EN:           avs_readdata <= {30'h0, irq_en};
        sgl_pkg::REG_COUNT:            avs_readdata <= {16'h0, count};
        default:                       avs_readdata <= 32'h0;
      endcase
    end
  end

  logic unused_rd;
  always_comb begin
    unused_rd = rd_strobe;
  end
endmodule

// ---- dv/host_sgl_builder.sv ----
// host model: packs descriptor fields into one 16-byte list entry
`timescale 1ns/1ps
module host_sgl_builder (
  input  wire logic         clock_in,
  input  wire logic         req_in,
  input  wire logic         raw_in,
  input  wire logic         dword_in,
  input  wire logic [7:0]   id_in,
  input  wire logic [63:0]  addr_in,
  input  wire logic [31:0]  len_in,
  output logic              desc_valid_out,
  output logic [127:0]      desc_out
);
  logic [1:0] keep;
  // raw_in lets a test hand over a misaligned entry on purpose
  assign keep = (dword_in && !raw_in) ? 2'h0 : 2'h3;
  always_ff @(posedge clock_in) begin
    desc_valid_out <= req_in;
    // idle cycles scramble the word so stale data never looks valid
    desc_out <= req_in ? {id_in, 24'h000000, len_in[31:2],
                          len_in[1:0] & keep, addr_in[63:2],
                          addr_in[1:0] & keep} : ~desc_out;
  end
endmodule

// ---- dv/sgl_decoder_props.sv ----
// concurrent checks on the descriptor decoder ports
`timescale 1ns/1ps
module sgl_decoder_props (
  input  wire logic          clock_in,
  input  wire logic          rst_in,
  input  wire logic          desc_valid_in,
  input  wire logic [127:0]  desc_in,
  input  wire logic          out_valid_out,
  input  wire logic [3:0]    out_type_out,
  input  wire logic [3:0]    out_sub_out,
  input  wire logic [63:0]   out_addr_out,
  input  wire logic [31:0]   out_len_out,
  input  wire logic          out_null_out,
  input  wire logic [2:0]    out_err_out,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic          avs_waitrequest
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic [3:0]  t;
  logic [64:0] sum;
  assign t = desc_in[127:124];
  assign sum = {1'b0, desc_in[63:0]} + {33'h0, desc_in[95:64]};
  sequence s_req; $rose(avs_read || avs_write); endsequence
  sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
  property p_answer; desc_valid_in |=> out_valid_out; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_quiet; !desc_valid_in |=> !out_valid_out; endproperty
  a_quiet: assert property (p_quiet) else $error("stray valid");
  property p_ident; desc_valid_in |=> out_type_out == $past(t) &&
    out_sub_out == $past(desc_in[123:120]); endproperty
  a_ident: assert property (p_ident) else $error("bad identifier");
  property p_reserved; desc_valid_in && t >= 4'h5 && t <= 4'hE |=>
    out_err_out == sgl_pkg::ERR_TYPE; endproperty
  a_reserved: assert property (p_reserved) else $error("bad type");
  property p_null; desc_valid_in && desc_in == '0 |=> out_null_out &&
    out_err_out == sgl_pkg::ERR_NONE; endproperty
  a_null: assert property (p_null) else $error("null refused");
  property p_hold; !desc_valid_in |=> $stable(out_addr_out) &&
    $stable(out_len_out); endproperty
  a_hold: assert property (p_hold) else $error("fields moved");
  property p_addr; desc_valid_in && desc_in[127:120] == 8'h00 |=>
    out_addr_out[63:2] == $past(desc_in[63:2]) &&
    out_len_out[31:2] == $past(desc_in[95:66]); endproperty
  a_addr: assert property (p_addr) else $error("bad data block");
  property p_overflow; desc_valid_in && desc_in[127:120] == 8'h00 &&
    desc_in[1:0] == 2'h0 && desc_in[65:64] == 2'h0 && sum[64] &&
    sum[63:0] != 64'h0 |=> out_err_out == sgl_pkg::ERR_LENGTH; endproperty
  a_overflow: assert property (p_overflow) else $error("no overflow");
  property p_wait; s_req |-> s_one_wait; endproperty
  a_wait: assert property (p_wait) else $error("bad wait state");
endmodule
bind sgl_descriptor_decoder sgl_decoder_props i_props (
  .clock_in(clock_in), .rst_in(rst_in), .desc_valid_in(desc_valid_in),
  .desc_in(desc_in), .out_valid_out(out_valid_out),
  .out_type_out(out_type_out), .out_sub_out(out_sub_out),
  .out_addr_out(out_addr_out), .out_len_out(out_len_out),
  .out_null_out(out_null_out), .out_err_out(out_err_out),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest));

// ---- dv/tb.sv ----
// self-checking bench for the descriptor decoder
`timescale 1ns/1ps
module tb;
  logic clock_in = 0, rst_in = 1, req = 0, raw = 0, dword = 1, xok = 0;
  logic [7:0] id = 8'h00;
  logic [63:0] addr = 64'h0, oaddr;
  logic [31:0] len = 32'h0, wd = 32'h0, rdata, olen;
  logic [4:0] ad = 5'h00;
  logic rd_r = 0, wr_r = 0, dv, ov, isoff, nul, wait_r, irq;
  logic [127:0] desc;
  logic [3:0] otype, osub;
  logic [2:0] oerr;
  int miscompares = 0, n_checks = 0;
  always #10 clock_in = ~clock_in;
  host_sgl_builder i_host_sgl_builder (.clock_in(clock_in), .req_in(req),
    .raw_in(raw), .dword_in(dword), .id_in(id), .addr_in(addr),
    .len_in(len), .desc_valid_out(dv), .desc_out(desc));
  sgl_descriptor_decoder i_sgl_descriptor_decoder (.clock_in(clock_in),
    .rst_in(rst_in), .desc_valid_in(dv), .desc_in(desc),
    .xport_sub_ok_in(xok), .out_valid_out(ov), .out_type_out(otype),
    .out_sub_out(osub), .out_addr_out(oaddr), .out_len_out(olen),
    .out_is_offset_out(isoff), .out_null_out(nul), .out_err_out(oerr),
    .avs_address(ad), .avs_read(rd_r), .avs_write(wr_r),
    .avs_writedata(wd), .avs_readdata(rdata),
    .avs_waitrequest(wait_r), .irq_out(irq));
  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // flops update by nba, so right after the edge we still see edge values;
  // one idle edge after release keeps strobes from being set twice at once
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    ad <= a; wd <= d; wr_r <= w; rd_r <= !w;
    do begin
      @(posedge clock_in);
    end while (wait_r !== 1'b0);
    r = rdata;
    wr_r <= 1'b0; rd_r <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
    if (a == 5'h00) dword <= d[0];
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk("readdata", {32'h0, e}, {32'h0, x});
  endtask
  // host model adds one cycle, the decoder one more
  task automatic send(input logic [7:0] i, input logic [63:0] a,
                      input logic [31:0] l, input logic rw,
                      input logic [2:0] e);
    id <= i; addr <= a; len <= l; raw <= rw; req <= 1'b1;
    @(posedge clock_in); req <= 1'b0;
    @(posedge clock_in); @(negedge clock_in);
    chk("valid", 64'h1, {63'h0, ov});
    chk("type", {60'h0, i[7:4]}, {60'h0, otype});
    chk("err", {61'h0, e}, {61'h0, oerr});
    @(posedge clock_in);
  endtask
  task automatic t_types();
    for (int k = 0; k < 16; k++)
      send({4'(k), 4'h0}, 64'h100, 32'h40, 1'b0,
           k <= 4 ? sgl_pkg::ERR_NONE : sgl_pkg::ERR_TYPE);
  endtask
  task automatic t_subs();
    send(8'h01, 64'h120, 32'h40, 1'b0, sgl_pkg::ERR_TYPE);
    send(8'h41, 64'h120, 32'h40, 1'b0, sgl_pkg::ERR_TYPE);
    send(8'h02, 64'h120, 32'h40, 1'b0, sgl_pkg::ERR_TYPE);
    wr(5'h00, 32'h04);
    send(8'h01, 64'h123, 32'h40, 1'b0, sgl_pkg::ERR_NONE);
    chk("offset", 64'h1, {63'h0, isoff});
    chk("addr", 64'h123, oaddr);
    wr(5'h00, 32'h0E);
    send(8'hF0, 64'h120, 32'h40, 1'b0, sgl_pkg::ERR_TYPE);
    wr(5'h00, 32'h1E); xok <= 1'b1;
    send(8'h0A, 64'h120, 32'h40, 1'b0, sgl_pkg::ERR_NONE);
    send(8'hFA, 64'h120, 32'h40, 1'b0, sgl_pkg::ERR_NONE);
    xok <= 1'b0;
    send(8'h0A, 64'h120, 32'h40, 1'b0, sgl_pkg::ERR_TYPE);
    wr(5'h00, 32'h07);
  endtask
  task automatic t_fields();
    send(8'h00, 64'h0, 32'h0, 1'b0, sgl_pkg::ERR_NONE);
    chk("null", 64'h1, {63'h0, nul});
    send(8'h00, 64'h103, 32'h40, 1'b1, sgl_pkg::ERR_FIELD);
    wr(5'h00, 32'h03);
    send(8'h00, 64'h103, 32'h41, 1'b1, sgl_pkg::ERR_NONE);
    chk("addr", 64'h100, oaddr);
    chk("len", 64'h40, {32'h0, olen});
    send(8'h00, 64'hFFFF_FFFF_FFFF_FF00, 32'h100, 1'b0,
         sgl_pkg::ERR_NONE);
    send(8'h00, 64'hFFFF_FFFF_FFFF_FF00, 32'h104, 1'b0,
         sgl_pkg::ERR_LENGTH);
    wr(5'h00, 32'h07);
  endtask
  task automatic t_irq();
    wr(5'h0C, 32'h3); wr(5'h10, 32'h0);
    send(8'h50, 64'h100, 32'h40, 1'b0, sgl_pkg::ERR_TYPE);
    rd(5'h08, 32'h3);
    chk("irq masked", 64'h0, {63'h0, irq});
    wr(5'h10, 32'h2); @(posedge clock_in);
    chk("irq", 64'h1, {63'h0, irq});
    wr(5'h0C, 32'h3); @(posedge clock_in);
    chk("irq cleared", 64'h0, {63'h0, irq});
    rd(5'h08, 32'h0);
  endtask
  task automatic conclude();
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    rd(5'h00, 32'h07);
    rd(5'h1C, 32'h0);
    wr(5'h1C, 32'hFF);
    t_types();
    t_subs();
    t_fields();
    t_irq();
    conclude();
  end
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
endmodule
